// ===== hw/wcc_pkg.sv
package wcc_pkg;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0]  ADDR_CTRL_A  = 8'h00;
    localparam logic [7:0]  ADDR_CTRL_B  = 8'h04;
    localparam logic [7:0]  ADDR_CNT_LO  = 8'h08;
    localparam logic [7:0]  ADDR_CNT_HI  = 8'h0C;
    localparam logic [7:0]  ADDR_CAP_LO  = 8'h10;
    localparam logic [7:0]  ADDR_CAP_HI  = 8'h14;
    localparam logic [7:0]  ADDR_FLAGS   = 8'h18;
    localparam logic [7:0]  ADDR_IRQ_EN  = 8'h1C;
    localparam logic [7:0]  ADDR_CMP     = 8'h20;
    localparam logic [7:0]  ADDR_NONE    = 8'hFC;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int          CB_TICK_LO   = 0;
    localparam int          CB_WGM_LO    = 3;
    localparam int          CB_EDGE      = 6;
    localparam int          CB_FILT      = 7;
    localparam int          FL_OVF       = 0;
    localparam int          FL_CAP       = 1;
    localparam int          CMP_SEL      = 0;
    localparam logic [7:0]  CTRL_RST     = 8'h00;

    // ----------------------------------------
    // counter limits and divider
    // ----------------------------------------
    localparam logic [15:0] CNT_BOTTOM   = 16'h0000;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT     = 16'h00FF;
    localparam logic [15:0] TOP_9BIT     = 16'h01FF;
    localparam logic [15:0] TOP_10BIT    = 16'h03FF;
    localparam int          DIV_W        = 10;
    localparam logic [9:0]  DIV8_MASK    = 10'h007;
    localparam logic [9:0]  DIV64_MASK   = 10'h03F;
    localparam logic [9:0]  DIV256_MASK  = 10'h0FF;
    localparam logic [9:0]  DIV1024_MASK = 10'h3FF;
    localparam int          FILT_SAMPLES = 4;

    // ----------------------------------------
    // tick sources and waveform modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        TS_STOP = 3'h0, TS_DIV1 = 3'h1, TS_DIV8 = 3'h2,
        TS_DIV64 = 3'h3, TS_DIV256 = 3'h4, TS_DIV1024 = 3'h5,
        TS_PIN_FALL = 3'h6, TS_PIN_RISE = 3'h7
    } wcc_tick_t;

    typedef enum logic [3:0] {
        M_NORMAL = 4'h0, M_PC8 = 4'h1, M_PC9 = 4'h2,
        M_PC10 = 4'h3, M_CTC_A = 4'h4, M_FAST8 = 4'h5,
        M_FAST9 = 4'h6, M_FAST10 = 4'h7, M_PFC_I = 4'h8,
        M_PFC_A = 4'h9, M_PC_I = 4'hA, M_PC_A = 4'hB,
        M_CTC_I = 4'hC, M_RSVD = 4'hD, M_FAST_I = 4'hE,
        M_FAST_A = 4'hF
    } wcc_mode_t;

    typedef struct packed {
        logic enable;
        logic filter_en;
        logic rising;
    } wcc_cap_cfg_t;

endpackage

// ===== hw/wcc_capture.sv
`timescale 1ns/1ps
`default_nettype none
module wcc_capture (
    // clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // configuration and trigger
    input  wire wcc_pkg::wcc_cap_cfg_t cfg,
    input  wire logic                  src_in,
    // event out
    output logic                       event_out
);
    import wcc_pkg::*;

    typedef struct packed {
        logic       s0;
        logic [2:0] sh;
        logic       filt;
        logic       lvl;
        logic       evt;
    } wcc_cap_st_t;

    wcc_cap_st_t r_reg;
    wcc_cap_st_t r_next;
    logic [FILT_SAMPLES-1:0] win;
    logic                    lvl_in;

    // ----------------------------------------
    // filter and edge detector
    // ----------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.s0 = src_in;
        r_next.sh = {r_reg.sh[1:0], r_reg.s0};
        win = {r_reg.sh, r_reg.s0};
        if (win == '0 || win == '1) begin
            r_next.filt = r_reg.s0;
        end
        lvl_in = cfg.filter_en ? r_reg.filt : r_reg.s0;
        r_next.lvl = lvl_in;
        r_next.evt = cfg.enable && (lvl_in != r_reg.lvl)
                     && (lvl_in == cfg.rising);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign event_out = r_reg.evt;

endmodule
`default_nettype wire

// ===== hw/wcc_timer.sv
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module wcc_timer #(
    parameter bit HAS_COMPARATOR = 1'b1
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // timer inputs
    input  wire logic        tick_pin,
    input  wire logic        capture_pin,
    input  wire logic        comparator_output,
    input  wire logic        capture_irq_ack,
    // status and requests
    output logic             capture_irq,
    output logic             overflow_irq,
    output logic             count_at_bottom,
    output logic             count_at_max
);
    import wcc_pkg::*;

    typedef struct packed {
        logic        rdy, resp, pend, pwr;
        logic [31:0] rdata;
        logic [7:0]  paddr, control_a, control_b, temp;
        logic        cmp_sel, down, overflow_flag, capture_flag;
        logic [1:0]  irq_en;
        logic [15:0] count_value, capture_register;
        logic [9:0]  div;
        logic        tick_prev, at_bot, at_max, cap_irq, ovf_irq;
    } wcc_state_t;

    localparam wcc_state_t ST_RESET = '{
        rdy: 1'b1, at_bot: 1'b1, default: '0};

    wcc_state_t   st_reg;
    wcc_state_t   st_next;
    wcc_mode_t    mode;
    logic [15:0]  top;
    wcc_cap_cfg_t cap_cfg;
    logic         tick, ovf_evt, cap_evt, accept, icr_mode, cap_src;

    // ----------------------------------------
    // mode decoding
    // ----------------------------------------
    function automatic logic uses_icr_top(input wcc_mode_t m);
        return m inside {M_PFC_I, M_PC_I, M_CTC_I, M_FAST_I};
    endfunction
    function automatic logic dual_slope(input wcc_mode_t m);
        return (m inside {M_PC8, M_PC9, M_PC10, M_PFC_I,
                          M_PFC_A, M_PC_I, M_PC_A});
    endfunction
    function automatic logic fast_pwm(input wcc_mode_t m);
        return (m inside {M_FAST8, M_FAST9, M_FAST10,
                          M_FAST_I, M_FAST_A});
    endfunction
    // no compare registers here, so their top falls back to max
    function automatic logic [15:0] mode_top(
        input wcc_mode_t   m,
        input logic [15:0] icr);
        case (m)
            M_PC8, M_FAST8:   return TOP_8BIT;
            M_PC9, M_FAST9:   return TOP_9BIT;
            M_PC10, M_FAST10: return TOP_10BIT;
            M_PFC_I, M_PC_I, M_CTC_I, M_FAST_I: return icr;
            default:          return CNT_MAX;
        endcase
    endfunction
    function automatic logic tick_hit(
        input logic [2:0] sel,
        input logic [9:0] div,
        input logic       pin,
        input logic       prev);
        case (sel)
            TS_STOP:     return 1'b0;
            TS_DIV1:     return 1'b1;
            TS_DIV8:     return (div & DIV8_MASK) == '0;
            TS_DIV64:    return (div & DIV64_MASK) == '0;
            TS_DIV256:   return (div & DIV256_MASK) == '0;
            TS_DIV1024:  return (div & DIV1024_MASK) == '0;
            TS_PIN_FALL: return prev && !pin;
            default:     return !prev && pin;
        endcase
    endfunction

    // ----------------------------------------
    // capture front end
    // ----------------------------------------
    // comparator as trigger
    // capture pin otherwise; an edge of the polarity set by CB_EDGE on the source triggers
    assign cap_src = (HAS_COMPARATOR && st_reg.cmp_sel)
                     ? comparator_output : capture_pin;
    assign icr_mode = uses_icr_top(mode);
    assign cap_cfg = '{enable: !icr_mode,
                       filter_en: st_reg.control_b[CB_FILT],
                       rising: st_reg.control_b[CB_EDGE]};

    wcc_capture u_capture (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .cfg       (cap_cfg),
        .src_in    (cap_src),
        .event_out (cap_evt)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        // mode split over a and b
        mode = wcc_mode_t'({st_reg.control_b[CB_WGM_LO+:2],
                            st_reg.control_a[1:0]});
        top = mode_top(mode, st_reg.capture_register);
        accept = hsel && hready && htrans[1];
        ovf_evt = 1'b0;
        st_next.div = st_reg.div + 10'h001;
        st_next.tick_prev = tick_pin;
        tick = tick_hit(st_reg.control_b[CB_TICK_LO+:3],
                        st_reg.div, tick_pin, st_reg.tick_prev);

        if (tick) begin
            if (dual_slope(mode)) begin
                if (!st_reg.down) begin
                    if (st_reg.count_value >= top) begin
                        st_next.down = 1'b1;
                        st_next.count_value = st_reg.count_value - 16'h0001;
                    end else begin
                        st_next.count_value = st_reg.count_value + 16'h0001;
                    end
                end else if (st_reg.count_value == CNT_BOTTOM) begin
                    st_next.down = 1'b0;
                    st_next.count_value = 16'h0001;
                    ovf_evt = 1'b1;
                end else begin
                    st_next.count_value = st_reg.count_value - 16'h0001;
                end
            end else begin
                st_next.down = 1'b0;
                if (st_reg.count_value == top) begin
                    st_next.count_value = CNT_BOTTOM;
                end else begin
                    st_next.count_value = st_reg.count_value + 16'h0001;
                end
                // fast at top, others at max
                ovf_evt = fast_pwm(mode)
                    ? (st_reg.count_value == top)
                    : (st_reg.count_value == CNT_MAX);
            end
        end

        // bus: one wait state, then read data or write done
        if (st_reg.pend) begin
            st_next.pend = 1'b0;
            st_next.rdy = 1'b1;
            if (st_reg.pwr) begin
                case (st_reg.paddr)
                    ADDR_CTRL_A: st_next.control_a = hwdata[7:0];
                    ADDR_CTRL_B: st_next.control_b = hwdata[7:0];
                    ADDR_CNT_HI, ADDR_CAP_HI: begin
                        st_next.temp = hwdata[7:0];
                    end
                    ADDR_CNT_LO: begin
                        st_next.count_value =
                            {st_reg.temp, hwdata[7:0]};
                    end
                    ADDR_CAP_LO: begin
                        if (icr_mode) begin
                            st_next.capture_register =
                                {st_reg.temp, hwdata[7:0]};
                        end
                    end
                    ADDR_FLAGS: begin
                        if (hwdata[FL_OVF]) begin
                            st_next.overflow_flag = 1'b0;
                        end
                        if (hwdata[FL_CAP]) begin
                            st_next.capture_flag = 1'b0;
                        end
                    end
                    ADDR_IRQ_EN: st_next.irq_en = hwdata[1:0];
                    ADDR_CMP: st_next.cmp_sel = hwdata[CMP_SEL];
                    default: ;
                endcase
            end else begin
                st_next.rdata = '0;
                case (st_reg.paddr)
                    ADDR_CTRL_A: st_next.rdata[7:0] = st_reg.control_a;
                    ADDR_CTRL_B: st_next.rdata[7:0] = st_reg.control_b;
                    ADDR_CNT_LO: begin
                        st_next.rdata[7:0] = st_reg.count_value[7:0];
                        st_next.temp = st_reg.count_value[15:8];
                    end
                    ADDR_CAP_LO: begin
                        st_next.rdata[7:0] =
                            st_reg.capture_register[7:0];
                        st_next.temp =
                            st_reg.capture_register[15:8];
                    end
                    ADDR_CNT_HI, ADDR_CAP_HI: begin
                        st_next.rdata[7:0] = st_reg.temp;
                    end
                    ADDR_FLAGS: begin
                        st_next.rdata[FL_OVF] = st_reg.overflow_flag;
                        st_next.rdata[FL_CAP] = st_reg.capture_flag;
                    end
                    ADDR_IRQ_EN: st_next.rdata[1:0] = st_reg.irq_en;
                    ADDR_CMP: st_next.rdata[CMP_SEL] = st_reg.cmp_sel;
                    default: ;
                endcase
            end
        end else if (accept) begin
            st_next.pend = 1'b1;
            st_next.rdy = 1'b0;
            st_next.pwr = hwrite;
            st_next.paddr = (haddr[31:8] == 24'h0000_00)
                            ? haddr[7:0] : ADDR_NONE;
        end

        // ack clears, set still wins below
        if (capture_irq_ack) begin
            st_next.capture_flag = 1'b0;
        end
        if (cap_evt) begin
            st_next.capture_register = st_reg.count_value;
            st_next.capture_flag = 1'b1;
        end
        if (ovf_evt) begin
            st_next.overflow_flag = 1'b1;
        end
        st_next.cap_irq = st_next.capture_flag && st_next.irq_en[FL_CAP];
        st_next.ovf_irq = st_next.overflow_flag && st_next.irq_en[FL_OVF];
        st_next.at_bot = st_next.count_value == CNT_BOTTOM;
        st_next.at_max = st_next.count_value == CNT_MAX;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hrdata = st_reg.rdata;
    assign hreadyout = st_reg.rdy;
    assign hresp = st_reg.resp;
    assign capture_irq = st_reg.cap_irq;
    assign overflow_irq = st_reg.ovf_irq;
    assign count_at_bottom = st_reg.at_bot;
    assign count_at_max = st_reg.at_max;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_lo_read_temp: assert property (
        st_reg.pend && !st_reg.pwr && st_reg.paddr == ADDR_CNT_LO
        |=> st_reg.temp == $past(st_reg.count_value[15:8]))
        else $error("count low read did not fill holding byte");

    a_lo_write_load: assert property (
        st_reg.pend && st_reg.pwr && st_reg.paddr == ADDR_CNT_LO
        |=> st_reg.count_value ==
            {$past(st_reg.temp), $past(hwdata[7:0])})
        else $error("count low write did not load both bytes");

    a_hi_read_temp: assert property (
        st_reg.pend && !st_reg.pwr && st_reg.paddr == ADDR_CNT_HI
        |=> hrdata == {24'h0000_00, $past(st_reg.temp)})
        else $error("count high read not from holding byte");

    a_stop_hold: assert property (
        st_reg.control_b[2:0] == TS_STOP
        && !(st_reg.pend && st_reg.pwr)
        |=> $stable(st_reg.count_value))
        else $error("stopped counter moved");

    a_cap_copy: assert property (
        cap_evt |=> st_reg.capture_flag
        && st_reg.capture_register == $past(st_reg.count_value))
        else $error("capture copy or flag missing");

    a_cap_off_icr: assert property (
        icr_mode && $past(icr_mode) |-> !cap_evt)
        else $error("capture in capture-top mode");

    a_flag_w1c: assert property (
        st_reg.pend && st_reg.pwr && st_reg.paddr == ADDR_FLAGS
        && hwdata[FL_CAP] && !cap_evt
        |=> !st_reg.capture_flag)
        else $error("capture flag not cleared by write");

    a_irq_ack: assert property (
        capture_irq_ack && !cap_evt
        |=> !st_reg.capture_flag && !capture_irq)
        else $error("ack did not clear capture flag");

    a_bottom_flag: assert property (
        count_at_bottom == (st_reg.count_value == CNT_BOTTOM))
        else $error("bottom condition wrong");

endmodule
`default_nettype wire

// ===== bench/wcc_event_src.sv
`timescale 1ns/1ps
`default_nettype none
module wcc_event_src (
    // clock
    input  wire logic hclk,
    // trigger lines
    output logic      capture_pin,
    output logic      comparator_output
);
    initial begin
        capture_pin       = 1'b0;
        comparator_output = 1'b0;
    end

    // pin level set like a port write
    // lines move only just after an edge, never mid-cycle
    task automatic set_line(input logic cmp, input logic val);
        @(posedge hclk);
        if (cmp) begin
            comparator_output <= val;
        end else begin
            capture_pin <= val;
        end
    endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import wcc_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        hclk, hresetn, hsel, hwrite, ack;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic        hreadyout, hresp, cap_irq, ovf_irq;
    logic        at_bot, at_max, pin, cmp, tpin;
    int          fail_count, cmp_count, n;

    always #25 hclk = ~hclk;

    wcc_event_src src (.hclk(hclk), .capture_pin(pin),
                       .comparator_output(cmp));

    wcc_timer #(.HAS_COMPARATOR(1'b1)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .tick_pin(tpin),
        .capture_pin(pin), .comparator_output(cmp),
        .capture_irq_ack(ack), .capture_irq(cap_irq),
        .overflow_irq(ovf_irq), .count_at_bottom(at_bot),
        .count_at_max(at_max));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // single word transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge hclk);
    endtask

    // edges until capture irq; 30 means no capture seen
    task automatic lat(input logic c, input logic val);
        src.set_line(c, val);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (cap_irq !== 1'b1 && n < 30);
    endtask

    // ----------------------------------------
    // watchdog and tests
    // ----------------------------------------
    initial begin
        idle(5000);
        fail_count++;
        summarize();
    end

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b1;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        ack = 1'b0;
        tpin = 1'b0;
        fail_count = 0;
        cmp_count = 0;
        idle(8);
        hresetn <= 1'b1;
        chk(at_bot, 1'b1);
        chk(at_max, 1'b0);
        rd(ADDR_CTRL_B);
        chk(v, 8'h00);
        rd(ADDR_NONE);
        chk(v, 8'h00);
        chk(hresp, 1'b0);
        wr(ADDR_CNT_HI, 8'hFF);
        wr(ADDR_CNT_LO, 8'hFF);
        idle(1);
        chk(at_max, 1'b1);
        chk(at_bot, 1'b0);
        idle(20);
        rd(ADDR_CNT_LO);
        chk(v, 8'hFF);
        wr(ADDR_IRQ_EN, 8'h01);
        wr(ADDR_CTRL_B, 8'h01);
        idle(4);
        chk(ovf_irq, 1'b1);
        chk(at_max, 1'b0);
        // write while counting: write wins, then counting resumes
        wr(ADDR_CNT_HI, 8'h12);
        wr(ADDR_CNT_LO, 8'h30);
        wr(ADDR_CTRL_B, 8'h00);
        rd(ADDR_CNT_LO);
        chk(v, 8'h34);
        rd(ADDR_CNT_HI);
        chk(v, 8'h12);
        wr(ADDR_FLAGS, 8'h01);
        idle(1);
        chk(ovf_irq, 1'b0);
        wr(ADDR_CNT_LO, 8'h34);
        wr(ADDR_CAP_HI, 8'h77);
        rd(ADDR_CNT_HI);
        chk(v, 8'h77);
        wr(ADDR_IRQ_EN, 8'h02);
        wr(ADDR_CTRL_B, 8'h40);
        lat(1'b0, 1'b1);
        chk(n, 4);
        rd(ADDR_CAP_LO);
        chk(v, 8'h34);
        rd(ADDR_CAP_HI);
        chk(v, 8'h12);
        wr(ADDR_FLAGS, 8'h00);
        chk(cap_irq, 1'b1);
        wr(ADDR_FLAGS, 8'h02);
        idle(1);
        chk(cap_irq, 1'b0);
        lat(1'b0, 1'b0);
        chk(n, 30);
        wr(ADDR_CTRL_B, 8'hC0);
        lat(1'b0, 1'b1);
        chk(n, 8);
        @(posedge hclk);
        ack <= 1'b1;
        @(posedge hclk);
        ack <= 1'b0;
        idle(2);
        chk(cap_irq, 1'b0);
        lat(1'b0, 1'b0);
        src.set_line(1'b0, 1'b1);
        idle(2);
        lat(1'b0, 1'b0);
        chk(n, 30);
        // flag cleared after the source change
        wr(ADDR_CTRL_B, 8'h40);
        wr(ADDR_CMP, 8'h01);
        wr(ADDR_FLAGS, 8'h02);
        lat(1'b1, 1'b1);
        chk(n, 4);
        wr(ADDR_FLAGS, 8'h02);
        lat(1'b0, 1'b1);
        chk(n, 30);
        wr(ADDR_CMP, 8'h00);
        wr(ADDR_CTRL_B, 8'h58);
        wr(ADDR_FLAGS, 8'h02);
        wr(ADDR_CNT_HI, 8'h0A);
        wr(ADDR_CAP_LO, 8'hBC);
        rd(ADDR_CAP_LO);
        chk(v, 8'hBC);
        rd(ADDR_CAP_HI);
        chk(v, 8'h0A);
        lat(1'b0, 1'b0);
        lat(1'b0, 1'b1);
        chk(n, 30);
        wr(ADDR_CTRL_B, 8'h40);
        wr(ADDR_CAP_HI, 8'h55);
        wr(ADDR_CAP_LO, 8'h66);
        rd(ADDR_CAP_LO);
        chk(v, 8'hBC);
        // three rising edges on the tick pin
        wr(ADDR_CTRL_B, 8'h07);
        repeat (3) begin
            @(posedge hclk);
            tpin <= 1'b1;
            @(posedge hclk);
            tpin <= 1'b0;
        end
        wr(ADDR_CTRL_B, 8'h00);
        rd(ADDR_CNT_LO);
        chk(v, 8'h37);
        summarize();
    end
endmodule
`default_nettype wire
